// ==== logic/sbut_params.svh ====
// Register offsets, field positions, reset values and divider limits of the up timer.
`ifndef SBUT_PARAMS_SVH
`define SBUT_PARAMS_SVH

`define SBUT_ADDR_MASK 8'h04
`define SBUT_ADDR_STATUS 8'h05
`define SBUT_ADDR_MODE 8'h06
`define SBUT_ADDR_EDGE 8'h0C

`define SBUT_RESET_MODE 8'h00
`define SBUT_RESET_EDGE 8'h00
`define SBUT_RESET_STATUS 8'h00
`define SBUT_RESET_MASK 8'h00
`define SBUT_RESET_COUNT 16'h0000

`define SBUT_EDGE_FALL_BIT 4
`define SBUT_FLAG_BIT 2
`define SBUT_TAP_BASE 16'h0100

`define SBUT_PIN_FAST 0
`define SBUT_PIN_CRYSTAL 1
`define SBUT_PIN_SLOW 2
`define SBUT_PIN_A4 3
`define SBUT_PIN_A0 4
`define SBUT_PIN_COUNT 5

`define SBUT_DIV1_LIMIT 6'h00
`define SBUT_DIV4_LIMIT 6'h03
`define SBUT_DIV16_LIMIT 6'h0F
`define SBUT_DIV64_LIMIT 6'h3F

`endif

// ==== logic/sbut_pkg.sv ====
// Types shared by the up timer and its prescaler.
package sbut_pkg;

  typedef enum logic [2:0] {
    SRC_STOP,
    SRC_SYSTEM_CLOCK,
    SRC_RESERVED,
    SRC_PORT_A_BIT_FOUR,
    SRC_INTERNAL_FAST,
    SRC_CRYSTAL,
    SRC_INTERNAL_SLOW,
    SRC_PORT_A_BIT_ZERO
  } sbut_src_e;

  typedef enum logic [1:0] {
    DIV_1,
    DIV_4,
    DIV_16,
    DIV_64
  } sbut_div_e;

  typedef struct packed {
    sbut_src_e src;
    sbut_div_e div;
    logic [2:0] tap;
  } sbut_mode_s;

  typedef struct packed {
    sbut_mode_s mode;
    logic [7:0] edgeSel;
    logic [7:0] status;
    logic [7:0] mask;
    logic [15:0] count;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic [7:0] rdData;
    logic [15:0] loadData;
    logic irq;
  } sbut_state_s;

  typedef struct packed {
    logic [5:0] cnt;
  } sbut_pre_state_s;

endpackage

// ==== logic/sbut_prescaler.sv ====
// Divides a stream of source ticks by 1, 4, 16 or 64.
`timescale 1ns/1ps
`include "sbut_params.svh"

module sbut_prescaler
  import sbut_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Tick stream.
  input wire logic tickIn,
  input sbut_div_e divSel,
  output logic tickOut
);

  sbut_pre_state_s st_reg;
  sbut_pre_state_s st_next;
  logic [5:0] limit;

  always_comb begin
    unique case (divSel)
      DIV_1: limit = `SBUT_DIV1_LIMIT;
      DIV_4: limit = `SBUT_DIV4_LIMIT;
      DIV_16: limit = `SBUT_DIV16_LIMIT;
      DIV_64: limit = `SBUT_DIV64_LIMIT;
    endcase
  end

  // Comparing with at-least lets a narrowed divider tick at once instead of running on to 63.
  assign tickOut = tickIn && (st_reg.cnt >= limit);

  always_comb begin
    st_next = st_reg;
    if (tickIn) begin
      st_next.cnt = tickOut ? 6'h00 : st_reg.cnt + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  property p_div64_gap;
    @(posedge clock) disable iff (srst)
      (tickOut && divSel == DIV_64 && $stable(divSel)) |=> (!tickOut) [*8];
  endproperty
  a_div64_gap: assert property (p_div64_gap) else $error("Divide by 64 ticked too soon.");

endmodule

// ==== logic/sbut_timer.sv ====
// Sixteen-bit up timer with clock select, prescaler, tap interrupt and register port.
//
// Operation
// - Mode field 7:5 selects clock; stop halts.
// - Prescaler divides by 1, 4, 16, 64.
// - Counter counts up once per prescaled tick.
// - Store instruction writes count; load reads count.
// - Tap field selects counter bit 8 to 15.
// - Edge select bit 4 picks rising or falling.
// - Tap transition sets interrupt flag bit 2.
// - Tap n fires every 2^(n+9) ticks.
// - Each pin event is one counter clock at divide by 1.
`timescale 1ns/1ps
`include "sbut_params.svh"

module sbut_timer
  import sbut_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Counter store and load instructions.
  input wire logic counterStore,
  input wire logic [15:0] counterStoreData,
  input wire logic counterLoad,
  output logic [15:0] counterLoadData,
  // Clock sources from outside this clock domain.
  input wire logic internalFastOscillator,
  input wire logic crystalOscillatorClock,
  input wire logic internalSlowOscillator,
  input wire logic portABitFourClock,
  input wire logic portABitZeroClock,
  // Interrupt.
  output logic timerIrq
);

  sbut_state_s st_reg;
  sbut_state_s st_next;
  logic [4:0] pinsIn;
  logic [4:0] pinRise;
  logic srcTick;
  logic cntTick;
  logic [15:0] countInc;
  logic [3:0] tapIdx;
  logic tapNow;
  logic tapInc;
  logic fallMode;
  logic tapEvent;
  logic [7:0] readMux;
  logic [7:0] setMask;
  logic [7:0] clrMask;

  assign pinsIn[`SBUT_PIN_FAST] = internalFastOscillator;
  assign pinsIn[`SBUT_PIN_CRYSTAL] = crystalOscillatorClock;
  assign pinsIn[`SBUT_PIN_SLOW] = internalSlowOscillator;
  assign pinsIn[`SBUT_PIN_A4] = portABitFourClock;
  assign pinsIn[`SBUT_PIN_A0] = portABitZeroClock;

  // Only the second synchroniser stage feeds the edge detector.
  assign pinRise = st_reg.sync2 & ~st_reg.prev;

  always_comb begin
    unique case (st_reg.mode.src)
      SRC_STOP: srcTick = 1'b0;
      SRC_SYSTEM_CLOCK: srcTick = 1'b1;
      SRC_RESERVED: srcTick = 1'b0;
      SRC_PORT_A_BIT_FOUR: srcTick = pinRise[`SBUT_PIN_A4];
      SRC_INTERNAL_FAST: srcTick = pinRise[`SBUT_PIN_FAST];
      SRC_CRYSTAL: srcTick = pinRise[`SBUT_PIN_CRYSTAL];
      SRC_INTERNAL_SLOW: srcTick = pinRise[`SBUT_PIN_SLOW];
      SRC_PORT_A_BIT_ZERO: srcTick = pinRise[`SBUT_PIN_A0];
    endcase
  end

  sbut_prescaler u_prescaler (
    .clock(clock),
    .srst(srst),
    .tickIn(srcTick),
    .divSel(st_reg.mode.div),
    .tickOut(cntTick)
  );

  // The increment wraps naturally from all ones to zero.
  assign countInc = st_reg.count + 16'h0001;
  assign tapIdx = {1'b1, st_reg.mode.tap};
  assign tapNow = st_reg.count[tapIdx];
  assign tapInc = countInc[tapIdx];
  assign fallMode = st_reg.edgeSel[`SBUT_EDGE_FALL_BIT];

  // A store overrides a tick and raises no event, so software can preset without a flag.
  assign tapEvent = cntTick && !counterStore &&
                    (fallMode ? (tapNow && !tapInc) : (!tapNow && tapInc));

  always_comb begin
    unique case (regAddr)
      `SBUT_ADDR_EDGE: readMux = st_reg.edgeSel;
      `SBUT_ADDR_MODE: readMux = st_reg.mode;
      `SBUT_ADDR_STATUS: readMux = st_reg.status;
      `SBUT_ADDR_MASK: readMux = st_reg.mask;
      default: readMux = 8'h00;
    endcase
  end

  always_comb begin
    setMask = 8'h00;
    setMask[`SBUT_FLAG_BIT] = tapEvent;
    clrMask = (regWrite && regAddr == `SBUT_ADDR_STATUS) ? regWrData : 8'h00;
  end

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = pinsIn;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    if (regWrite) begin
      unique case (regAddr)
        `SBUT_ADDR_EDGE: st_next.edgeSel = regWrData;
        `SBUT_ADDR_MODE: st_next.mode = sbut_mode_s'(regWrData);
        `SBUT_ADDR_MASK: st_next.mask = regWrData;
        default: st_next.mask = st_reg.mask;
      endcase
    end
    // A new event beats a write-one clear in the same cycle.
    st_next.status = (st_reg.status & ~clrMask) | setMask;
    if (counterStore) begin
      st_next.count = counterStoreData;
    end else if (cntTick) begin
      st_next.count = countInc;
    end
    if (counterLoad) begin
      st_next.loadData = st_reg.count;
    end
    st_next.rdData = regRead ? readMux : 8'h00;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg.mode <= `SBUT_RESET_MODE;
      st_reg.edgeSel <= `SBUT_RESET_EDGE;
      st_reg.status <= `SBUT_RESET_STATUS;
      st_reg.mask <= `SBUT_RESET_MASK;
      st_reg.count <= `SBUT_RESET_COUNT;
      st_reg.sync1 <= 5'h00;
      st_reg.sync2 <= 5'h00;
      st_reg.prev <= 5'h00;
      st_reg.rdData <= 8'h00;
      st_reg.loadData <= 16'h0000;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData = st_reg.rdData;
  assign counterLoadData = st_reg.loadData;
  assign timerIrq = st_reg.irq;

  property p_stop_holds;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_STOP && !counterStore) |=> $stable(st_reg.count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("Count moved while stopped.");

  property p_sys_div1;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_SYSTEM_CLOCK && st_reg.mode.div == DIV_1 && !counterStore)
        |-> cntTick;
  endproperty
  a_sys_div1: assert property (p_sys_div1) else $error("System clock divide by one missed.");

  property p_count_up;
    @(posedge clock) disable iff (srst)
      (cntTick && !counterStore) |=> (st_reg.count == $past(st_reg.count) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("Counter did not advance by one.");

  property p_store;
    @(posedge clock) disable iff (srst)
      counterStore |=> (st_reg.count == $past(counterStoreData));
  endproperty
  a_store: assert property (p_store) else $error("Stored value not taken.");

  property p_load;
    @(posedge clock) disable iff (srst)
      counterLoad |=> (counterLoadData == $past(st_reg.count));
  endproperty
  a_load: assert property (p_load) else $error("Loaded value differs from count.");

  property p_tap_flag;
    @(posedge clock) disable iff (srst)
      (cntTick && !counterStore && !fallMode && !st_reg.count[tapIdx] &&
       countInc[tapIdx]) |=> st_reg.status[`SBUT_FLAG_BIT];
  endproperty
  a_tap_flag: assert property (p_tap_flag) else $error("Rising tap did not set the flag.");

  property p_fall_flag;
    @(posedge clock) disable iff (srst)
      (cntTick && !counterStore && fallMode && st_reg.count[tapIdx] && !countInc[tapIdx])
        |=> st_reg.status[`SBUT_FLAG_BIT] ##1 1'b1;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("Falling tap did not set flag.");

  property p_flag_cause;
    @(posedge clock) disable iff (srst)
      $rose(st_reg.status[`SBUT_FLAG_BIT]) |-> $past(tapEvent);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("Flag set without tap event.");

  property p_period;
    @(posedge clock) disable iff (srst)
      tapEvent |=> ((st_reg.count & ((`SBUT_TAP_BASE << $past(st_reg.mode.tap)) - 16'h0001))
        == 16'h0000);
  endproperty
  a_period: assert property (p_period) else $error("Tap event off its period.");

  property p_pin_count;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_PORT_A_BIT_ZERO && st_reg.mode.div == DIV_1 &&
       pinRise[`SBUT_PIN_A0] && !counterStore)
        |=> (st_reg.count == $past(st_reg.count) + 16'h0001);
  endproperty
  a_pin_count: assert property (p_pin_count) else $error("Pin event not counted.");

  property p_wrap;
    @(posedge clock) disable iff (srst)
      (st_reg.count == 16'hFFFF && cntTick && !counterStore) |=> (st_reg.count == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Counter did not wrap to zero.");

  property p_irq;
    @(posedge clock) disable iff (srst)
      timerIrq == (|(st_reg.status & st_reg.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt level disagrees with status.");

  property p_rsv_holds;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_RESERVED && !counterStore) |=> $stable(st_reg.count);
  endproperty
  a_rsv_holds: assert property (p_rsv_holds) else $error("Reserved source counted.");

  property p_stop_quiet;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_STOP) |-> !srcTick;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("Stopped source ticked.");

  property p_sys_tick;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_SYSTEM_CLOCK) |-> srcTick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("System clock tick missing.");

  property p_tick_src;
    @(posedge clock) disable iff (srst)
      cntTick |-> srcTick;
  endproperty
  a_tick_src: assert property (p_tick_src) else $error("Prescaled tick without source.");

  property p_no_down;
    @(posedge clock) disable iff (srst)
      !counterStore |=> (st_reg.count == $past(st_reg.count) ||
        st_reg.count == $past(st_reg.count) + 16'h0001);
  endproperty
  a_no_down: assert property (p_no_down) else $error("Counter moved other than up.");

  property p_idle_holds;
    @(posedge clock) disable iff (srst)
      (!cntTick && !counterStore) |=> $stable(st_reg.count);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("Count moved without a tick.");

  property p_store_quiet;
    @(posedge clock) disable iff (srst)
      (counterStore && !st_reg.status[`SBUT_FLAG_BIT]) |=> !st_reg.status[`SBUT_FLAG_BIT];
  endproperty
  a_store_quiet: assert property (p_store_quiet) else $error("Store raised the flag.");

  property p_load_holds;
    @(posedge clock) disable iff (srst)
      !counterLoad |=> $stable(counterLoadData);
  endproperty
  a_load_holds: assert property (p_load_holds) else $error("Loaded value changed alone.");

  property p_tap_range;
    @(posedge clock) disable iff (srst)
      tapEvent |-> (countInc[7:0] == 8'h00);
  endproperty
  a_tap_range: assert property (p_tap_range) else $error("Event from a low counter bit.");

  property p_edge_write;
    @(posedge clock) disable iff (srst)
      (regWrite && regAddr == `SBUT_ADDR_EDGE) |=> (st_reg.edgeSel == $past(regWrData));
  endproperty
  a_edge_write: assert property (p_edge_write) else $error("Edge select not written.");

  property p_edge_read;
    @(posedge clock) disable iff (srst)
      (regRead && regAddr == `SBUT_ADDR_EDGE) |=> (regRdData == $past(st_reg.edgeSel));
  endproperty
  a_edge_read: assert property (p_edge_read) else $error("Edge select read wrong.");

  property p_mode_write;
    @(posedge clock) disable iff (srst)
      (regWrite && regAddr == `SBUT_ADDR_MODE)
        |=> (st_reg.mode == sbut_mode_s'($past(regWrData)));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Mode not written.");

  property p_flag_sticky;
    @(posedge clock) disable iff (srst)
      (st_reg.status[`SBUT_FLAG_BIT] && !(regWrite && regAddr == `SBUT_ADDR_STATUS))
        |=> st_reg.status[`SBUT_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Flag dropped by itself.");

  property p_flag_clear;
    @(posedge clock) disable iff (srst)
      (regWrite && regAddr == `SBUT_ADDR_STATUS && regWrData[`SBUT_FLAG_BIT] && !tapEvent)
        |=> !st_reg.status[`SBUT_FLAG_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Write one did not clear.");

  property p_status_unused;
    @(posedge clock) disable iff (srst)
      (st_reg.status[7:3] == 5'h00) && (st_reg.status[1:0] == 2'h0);
  endproperty
  a_status_unused: assert property (p_status_unused) else $error("Unused status bit set.");

  property p_pin_a4;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_PORT_A_BIT_FOUR && st_reg.mode.div == DIV_1 &&
       pinRise[`SBUT_PIN_A4] && !counterStore)
        |=> (st_reg.count == $past(st_reg.count) + 16'h0001);
  endproperty
  a_pin_a4: assert property (p_pin_a4) else $error("Pin four event not counted.");

  property p_pin_quiet;
    @(posedge clock) disable iff (srst)
      (st_reg.mode.src == SRC_PORT_A_BIT_ZERO && !pinRise[`SBUT_PIN_A0]) |-> !cntTick;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("Counted without a pin event.");

  property p_top_fall;
    @(posedge clock) disable iff (srst)
      (st_reg.count == 16'hFFFF && cntTick && !counterStore && fallMode &&
       st_reg.mode.tap == 3'h7) |=> st_reg.status[`SBUT_FLAG_BIT];
  endproperty
  a_top_fall: assert property (p_top_fall) else $error("Wrap raised no overflow flag.");

endmodule

// ==== bench/sixteen_bit_up_timer_tb.sv ====
// Self-checking bench of the sixteen-bit up timer.
`timescale 1ns/1ps
`include "sbut_params.svh"

module sixteen_bit_up_timer_tb;
  import sbut_pkg::*;
  logic clock, srst, regWrite, regRead, counterStore, counterLoad, timerIrq;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [15:0] counterStoreData, counterLoadData, base;
  logic [4:0] pins;
  int errTotal, nCompared;
  integer seed;

  sbut_timer DUT (.clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .counterStore(counterStore), .counterStoreData(counterStoreData),
    .counterLoad(counterLoad), .counterLoadData(counterLoadData),
    .internalFastOscillator(pins[0]), .crystalOscillatorClock(pins[1]),
    .internalSlowOscillator(pins[2]), .portABitFourClock(pins[3]),
    .portABitZeroClock(pins[4]), .timerIrq(timerIrq));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic testDone;
    $display("Compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Pin j carries j+1 pulses per run; the system clock gives one tick per cycle.
  function automatic int src_ticks(input int src, input int dv);
    case (src)
      1: return 128 >> (2 * dv);
      3: return 4;
      4: return 1;
      5: return 2;
      6: return 3;
      7: return 5;
      default: return 0;
    endcase
  endfunction

  function automatic logic [7:0] mode_byte(input int src, input int dv, input int tap);
    return {src[2:0], dv[1:0], tap[2:0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk("register", regRdData, exp);
  endtask

  task automatic st(input logic [15:0] v);
    @(posedge clock);
    counterStore <= 1'b1;
    counterStoreData <= v;
    @(posedge clock);
    counterStore <= 1'b0;
  endtask

  task automatic ld(input logic [15:0] exp);
    @(posedge clock);
    counterLoad <= 1'b1;
    @(posedge clock);
    counterLoad <= 1'b0;
    #1 chk("count", counterLoadData, exp);
  endtask

  // A brief system-clock pass at divide by one zeroes the prescaler phase, so each run
  // counts whole periods from its first source tick.
  task automatic run(input int src, input int dv);
    int c;
    int j;
    base = 16'($random(seed));
    wr(`SBUT_ADDR_MODE, mode_byte(1, 0, 0));
    wr(`SBUT_ADDR_MODE, mode_byte(0, dv, 0));
    st(base);
    wr(`SBUT_ADDR_MODE, mode_byte(src, dv, 0));
    for (c = 0; c < 126; c++) begin
      @(posedge clock);
      for (j = 0; j < 5; j++) begin
        pins[j] <= (c >= 8) && (c < 8 + 8 * (j + 1)) && (c % 8 >= 4);
      end
    end
    wr(`SBUT_ADDR_MODE, mode_byte(0, dv, 0));
    ld(base + 16'(src_ticks(src, dv)));
  endtask

  // The tap edge is reached exactly four ticks after the timer starts.
  task automatic irq_case(input int t, input int fall);
    logic [31:0] v;
    v = (32'h1 << (8 + t + fall)) - 32'h4;
    wr(`SBUT_ADDR_MODE, 8'h00);
    st(v[15:0]);
    wr(`SBUT_ADDR_STATUS, 8'h04);
    wr(`SBUT_ADDR_MASK, t[0] ? 8'h04 : 8'h00);
    wr(`SBUT_ADDR_EDGE, fall ? 8'h10 : 8'h00);
    wr(`SBUT_ADDR_MODE, mode_byte(1, 0, t));
    repeat (2) @(posedge clock);
    #1 chk("irq early", {15'h0000, timerIrq}, 16'h0000);
    repeat (2) @(posedge clock);
    #1 chk("irq", {15'h0000, timerIrq}, {15'h0000, t[0]});
    wr(`SBUT_ADDR_MODE, 8'h00);
    rd(`SBUT_ADDR_STATUS, 8'h04);
    wr(`SBUT_ADDR_STATUS, 8'h04);
    rd(`SBUT_ADDR_STATUS, 8'h00);
    chk("irq cleared", {15'h0000, timerIrq}, 16'h0000);
  endtask

  initial begin
    repeat (50000) @(posedge clock);
    errTotal++;
    testDone();
  end

  initial begin
    logic [7:0] r;
    seed = 32'hFD51;
    srst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    counterStore = 1'b0;
    counterStoreData = 16'h0000;
    counterLoad = 1'b0;
    pins = 5'h00;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rd(`SBUT_ADDR_MODE, `SBUT_RESET_MODE);
    rd(`SBUT_ADDR_EDGE, `SBUT_RESET_EDGE);
    rd(`SBUT_ADDR_STATUS, `SBUT_RESET_STATUS);
    rd(`SBUT_ADDR_MASK, `SBUT_RESET_MASK);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(`SBUT_ADDR_EDGE, 8'hA5);
    rd(`SBUT_ADDR_EDGE, 8'hA5);
    r = 8'($random(seed));
    wr(`SBUT_ADDR_MODE, r);
    rd(`SBUT_ADDR_MODE, r);
    for (int s = 0; s < 8; s++) begin
      run(s, 0);
    end
    for (int d = 1; d < 4; d++) begin
      run(1, d);
    end
    for (int t = 0; t < 8; t++) begin
      irq_case(t, 0);
      irq_case(t, 1);
    end
    testDone();
  end
endmodule
